/* rtl/drc_rate_config.sv */
/*
 spreading rate configuration: wishbone register slave holding the rate
 register and code half select, and registered mode outputs for the
 correlator and serializer.
 assumes classic wishbone, 32-bit data, single clock core_clk at 40 MHz.
*/
// Chosen here: register access over Wishbone.
// Contract
// - chip-length bit one picks 32-chip codes, zero picks 64-chip codes.
// - rate bit one carries two bits per code, zero one bit.
// - rate bit honoured only with 32-chip codes; 64-chip forces one bit.
// - double rate splits the stored 64-chip code into two 32-chip halves.
// - throughput 62.5 kbit/s double rate, 32 kbit/s normal rate.
// - normal rate 32-chip mode may correlate against two differing codes.
// - oversampling bit one gives twelve samples per chip, zero six.
// - oversampling ignored for 64-chip or double rate; 12x only 32-chip normal.
// - 32-chip normal rate: half select one uses upper chips, zero lower.
`timescale 1ns/10ps
module drc_rate_config
    import drc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // effective spreading mode
    output drc_mode_type spreadMode,
    output logic [6:0] chipsPerCode,
    output logic [1:0] bitsPerCode,
    output logic [3:0] samplesPerChip,
    output logic [16:0] rawRateBps,
    output logic splitCode,
    output logic dualCodeOk,
    output logic useUpperHalf
);
    logic [7:0] rateCfg_r, rateCfg_nxt;
    logic codeHalf_r, codeHalf_nxt;
    logic [31:0] datOut_r, datOut_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    drc_mode_type modeComb, mode_r;
    logic [6:0] chipsComb, chips_r;
    logic [1:0] bitsComb, bits_r;
    logic [3:0] sampComb, samp_r;
    logic [16:0] rateComb, rateBps_r;
    logic splitComb, split_r;
    logic dualComb, dual_r;
    logic upperComb, upper_r;
    logic access;
    logic hitRate, hitCode, hitStat;

    assign access = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    assign hitRate = (wb_adr_i == RATE_CFG_OFFSET);
    assign hitCode = (wb_adr_i == CODE_CTL_OFFSET);
    assign hitStat = (wb_adr_i == MODE_STAT_OFFSET);

    // register file and bus answer; one wait-free cycle, ack then drop
    always_comb begin
        rateCfg_nxt = rateCfg_r;
        codeHalf_nxt = codeHalf_r;
        datOut_nxt = datOut_r;
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        if (access) begin
            if (hitRate || hitCode || hitStat) begin
                ack_nxt = 1'b1;
            end else begin
                err_nxt = 1'b1; // unmapped address answers with err
            end
            if (wb_we_i && wb_sel_i[0]) begin
                // upper rate bits 7:3 are stored as written; software keeps them zero
                if (hitRate) begin
                    rateCfg_nxt = wb_dat_i[7:0];
                end
                if (hitCode) begin
                    codeHalf_nxt = wb_dat_i[CODE_HALF_BIT];
                end
            end
            datOut_nxt = 32'h0000_0000;
            if (!wb_we_i) begin
                if (hitRate) begin
                    datOut_nxt = {24'h00_0000, rateCfg_r};
                end else if (hitCode) begin
                    datOut_nxt = {31'h0000_0000, codeHalf_r};
                end else if (hitStat) begin
                    datOut_nxt = {28'h000_0000, mode_r};
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rateCfg_r <= RATE_CFG_RESET;
            codeHalf_r <= CODE_CTL_RESET[0];
            datOut_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            rateCfg_r <= rateCfg_nxt;
            codeHalf_r <= codeHalf_nxt;
            datOut_r <= datOut_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
        end
    end

    // one decoder so the correlator never sees a mixed configuration
    drc_mode_decode u_decode (
        .chipShort(rateCfg_r[CHIP_LEN_BIT]),
        .doubleRate(rateCfg_r[DOUBLE_RATE_BIT]),
        .overSample(rateCfg_r[OVERSAMPLE_BIT]),
        .codeHalf(codeHalf_r),
        .mode(modeComb),
        .chipsPerCode(chipsComb),
        .bitsPerCode(bitsComb),
        .samplesPerChip(sampComb),
        .rawRateBps(rateComb),
        .splitCode(splitComb),
        .dualCodeOk(dualComb),
        .useUpperHalf(upperComb)
    );

    // mode outputs registered: one cycle after the register write lands
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= MODE_LONG;
            chips_r <= CHIPS_LONG;
            bits_r <= 2'd1;
            samp_r <= SAMPLES_COARSE;
            rateBps_r <= RATE_NORMAL_BPS;
            split_r <= 1'b0;
            dual_r <= 1'b0;
            upper_r <= 1'b0;
        end else begin
            mode_r <= modeComb;
            chips_r <= chipsComb;
            bits_r <= bitsComb;
            samp_r <= sampComb;
            rateBps_r <= rateComb;
            split_r <= splitComb;
            dual_r <= dualComb;
            upper_r <= upperComb;
        end
    end

    assign wb_dat_o = datOut_r;
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign spreadMode = mode_r;
    assign chipsPerCode = chips_r;
    assign bitsPerCode = bits_r;
    assign samplesPerChip = samp_r;
    assign rawRateBps = rateBps_r;
    assign splitCode = split_r;
    assign dualCodeOk = dual_r;
    assign useUpperHalf = upper_r;

    // assertions
    sequence seqRateWrite;
        access && wb_we_i && wb_sel_i[0] && hitRate;
    endsequence

    AST_LONG_CHIPS: assert property (@(posedge core_clk) disable iff (!reset_n)
        !rateCfg_r[CHIP_LEN_BIT] |=> chipsPerCode == CHIPS_LONG)
        else $error("64-chip length not applied");
    AST_SHORT_CHIPS: assert property (@(posedge core_clk) disable iff (!reset_n)
        rateCfg_r[CHIP_LEN_BIT] |=> chipsPerCode == CHIPS_SHORT)
        else $error("32-chip length not applied");
    AST_DOUBLE_BITS: assert property (@(posedge core_clk) disable iff (!reset_n)
        rateCfg_r[2:1] == 2'b11 |=> bitsPerCode == 2'd2 && splitCode)
        else $error("double rate not applied");
    AST_LONG_ONE_BIT: assert property (@(posedge core_clk) disable iff (!reset_n)
        !rateCfg_r[CHIP_LEN_BIT] |=> bitsPerCode == 2'd1 && !splitCode)
        else $error("rate bit honoured with 64-chip codes");
    AST_SPLIT_HALVES: assert property (@(posedge core_clk) disable iff (!reset_n)
        splitCode |-> chipsPerCode == CHIPS_SHORT && spreadMode == MODE_SHORT_DOUBLE)
        else $error("code split outside double rate");
    AST_THROUGHPUT: assert property (@(posedge core_clk) disable iff (!reset_n)
        rawRateBps == (bitsPerCode == 2'd2 ? RATE_DOUBLE_BPS : RATE_NORMAL_BPS))
        else $error("throughput mismatch");
    AST_DUAL_CODE: assert property (@(posedge core_clk) disable iff (!reset_n)
        dualCodeOk |-> chipsPerCode == CHIPS_SHORT && bitsPerCode == 2'd1)
        else $error("dual code outside 32-chip normal rate");
    AST_FINE_SAMPLE: assert property (@(posedge core_clk) disable iff (!reset_n)
        rateCfg_r[2:0] == 3'b101 |=> samplesPerChip == SAMPLES_FINE)
        else $error("12x sampling not applied");
    AST_SAMPLE_IGNORED: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!rateCfg_r[CHIP_LEN_BIT] || rateCfg_r[DOUBLE_RATE_BIT])
        |=> samplesPerChip == SAMPLES_COARSE)
        else $error("oversampling not ignored");
    // half select output lags its register by one cycle, so look one cycle back
    AST_UPPER_HALF: assert property (@(posedge core_clk) disable iff (!reset_n)
        useUpperHalf |-> $past(codeHalf_r) && dualCodeOk)
        else $error("upper half chosen wrongly");
    // written chip length reaches the mode outputs one edge after the taking edge; the check samples it at the second
    AST_WRITE_TO_MODE: assert property (@(posedge core_clk) disable iff (!reset_n)
        seqRateWrite |-> ##2 (spreadMode[0] == !$past(wb_dat_i[CHIP_LEN_BIT], 2)))
        else $error("mode did not follow register");

    // bus side: stored value, one-cycle answers, refused addresses
    sequence seqUnmapped;
        access && !(hitRate || hitCode || hitStat);
    endsequence

    AST_RATE_STORED: assert property (@(posedge core_clk) disable iff (!reset_n)
        seqRateWrite |=> rateCfg_r == $past(wb_dat_i[7:0]))
        else $error("rate register write lost");
    AST_ACK_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o && !wb_err_o)
        else $error("ack held longer than one cycle");
    AST_ERR_UNMAPPED: assert property (@(posedge core_clk) disable iff (!reset_n)
        seqUnmapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped address not refused");
endmodule

/* inc/drc_pkg.sv */
/*
 package for the spreading rate configuration block: register offsets,
 field positions, reset values and mode encodings.
 assumes a classic wishbone slave with 32-bit data, byte addresses.
*/
package drc_pkg;
    // register byte offsets and reset values
    localparam logic [7:0] RATE_CFG_OFFSET = 8'h04;
    localparam logic [7:0] CODE_CTL_OFFSET = 8'h40;
    localparam logic [7:0] MODE_STAT_OFFSET = 8'h44;
    localparam logic [7:0] RATE_CFG_RESET = 8'h00;
    localparam logic [7:0] CODE_CTL_RESET = 8'h00;
    // rate configuration fields
    localparam int CHIP_LEN_BIT = 2;
    localparam int DOUBLE_RATE_BIT = 1;
    localparam int OVERSAMPLE_BIT = 0;
    localparam int RATE_CFG_WIDTH = 3;
    // code control field
    localparam int CODE_HALF_BIT = 0;
    // chip lengths and samples per chip
    localparam logic [6:0] CHIPS_LONG = 7'h40;
    localparam logic [6:0] CHIPS_SHORT = 7'h20;
    localparam logic [3:0] SAMPLES_FINE = 4'hc;
    localparam logic [3:0] SAMPLES_COARSE = 4'h6;
    // raw throughput in bits per second
    localparam logic [16:0] RATE_DOUBLE_BPS = 17'h0_f424;
    localparam logic [16:0] RATE_NORMAL_BPS = 17'h0_7d00;
    // effective spreading mode, one-hot
    typedef enum logic [3:0] {
        MODE_LONG = 4'b0001,
        MODE_SHORT_NORMAL = 4'b0010,
        MODE_SHORT_FINE = 4'b0100,
        MODE_SHORT_DOUBLE = 4'b1000
    } drc_mode_type;
endpackage

/* rtl/drc_mode_decode.sv */
/*
 combinational decoder from the three rate fields and the code half select
 to one effective spreading mode and its parameters.
 assumes its inputs come from registers in the same clock domain.
*/
`timescale 1ns/10ps
module drc_mode_decode
    import drc_pkg::*;
(
    // configuration fields
    input wire logic chipShort,
    input wire logic doubleRate,
    input wire logic overSample,
    input wire logic codeHalf,
    // decoded mode
    output drc_mode_type mode,
    output logic [6:0] chipsPerCode,
    output logic [1:0] bitsPerCode,
    output logic [3:0] samplesPerChip,
    output logic [16:0] rawRateBps,
    output logic splitCode,
    output logic dualCodeOk,
    output logic useUpperHalf
);
    // single decode keeps length, bits and sampling always consistent
    always_comb begin
        if (!chipShort) begin
            mode = MODE_LONG;
        end else if (doubleRate) begin
            mode = MODE_SHORT_DOUBLE;
        end else if (overSample) begin
            mode = MODE_SHORT_FINE;
        end else begin
            mode = MODE_SHORT_NORMAL;
        end
    end

    // per-mode parameters
    always_comb begin
        chipsPerCode = CHIPS_SHORT;
        bitsPerCode = 2'd1;
        samplesPerChip = SAMPLES_COARSE;
        rawRateBps = RATE_NORMAL_BPS;
        splitCode = 1'b0;
        dualCodeOk = 1'b0;
        useUpperHalf = 1'b0;
        case (mode)
            MODE_LONG: begin
                chipsPerCode = CHIPS_LONG;
            end
            MODE_SHORT_DOUBLE: begin
                bitsPerCode = 2'd2;
                rawRateBps = RATE_DOUBLE_BPS;
                splitCode = 1'b1;
            end
            MODE_SHORT_FINE: begin
                samplesPerChip = SAMPLES_FINE;
                dualCodeOk = 1'b1;
                useUpperHalf = codeHalf;
            end
            MODE_SHORT_NORMAL: begin
                dualCodeOk = 1'b1;
                useUpperHalf = codeHalf;
            end
            default: begin
                chipsPerCode = CHIPS_LONG;
            end
        endcase
    end
endmodule

/* bench/drc_rate_config_tb.sv */
/*
 testbench for drc_rate_config: wishbone tasks with an expected-answer
 queue, and port checks of the decoded mode over every field combination.
 assumes drc_pkg and the design are compiled before it.
*/
`timescale 1ns/10ps
module drc_rate_config_tb;
    import drc_pkg::*;
    // design inputs and outputs
    logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, wb_err_o, splitCode, dualCodeOk, useUpperHalf;
    drc_mode_type spreadMode;
    logic [6:0] chipsPerCode;
    logic [1:0] bitsPerCode;
    logic [3:0] samplesPerChip;
    logic [16:0] rawRateBps;
    // bookkeeping: note is {compare data, expect err, read data}
    int miscompares = 0;
    int checks_done = 0;
    logic [33:0] noteQ[$];
    logic [33:0] note;
    logic [7:0] cfg;
    logic [31:0] rnd;

    drc_rate_config dut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .spreadMode(spreadMode), .chipsPerCode(chipsPerCode), .bitsPerCode(bitsPerCode),
        .samplesPerChip(samplesPerChip), .rawRateBps(rawRateBps), .splitCode(splitCode),
        .dualCodeOk(dualCodeOk), .useUpperHalf(useUpperHalf));

    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // the mode the correlator should see for a given rate register value
    function automatic logic [3:0] expMode(input logic [7:0] c);
        if (!c[CHIP_LEN_BIT]) return 4'b0001;
        if (c[DOUBLE_RATE_BIT]) return 4'b1000;
        return c[OVERSAMPLE_BIT] ? 4'b0100 : 4'b0010;
    endfunction

    // one classic cycle; waits are bounded so a dead slave ends the run
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat, input logic [33:0] exp);
        int n;
        noteQ.push_back(exp);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        n = 0;
        // answer sampled at the rising edge; request released at that same edge
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            miscompares++;
            test_done();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic chkMode(input logic [7:0] c, input logic h);
        logic s, d, o;
        s = c[CHIP_LEN_BIT];
        d = c[DOUBLE_RATE_BIT];
        o = c[OVERSAMPLE_BIT];
        cmp(spreadMode, expMode(c));
        cmp(chipsPerCode, s ? 7'h20 : 7'h40);
        cmp(bitsPerCode, (s && d) ? 2'h2 : 2'h1);
        cmp(samplesPerChip, (s && !d && o) ? 4'hc : 4'h6);
        cmp(rawRateBps, (s && d) ? 17'h0_f424 : 17'h0_7d00);
        cmp(splitCode, s && d);
        cmp(dualCodeOk, s && !d);
        cmp(useUpperHalf, s && !d && h);
    endtask

    // answers are matched in order against the oldest note
    always @(negedge core_clk) begin
        if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
            note = noteQ.pop_front();
            cmp({31'h0, wb_err_o}, {31'h0, note[32]});
            if (note[33]) begin
                cmp(wb_dat_o, note[31:0]);
            end
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        reset_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        rnd = $urandom(32'h8488);
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chkMode(8'h00, 1'b0);
        bus(1'b0, RATE_CFG_OFFSET, 4'hf, 32'h0, {2'b10, 32'h0});
        bus(1'b0, CODE_CTL_OFFSET, 4'hf, 32'h0, {2'b10, 32'h0});
        bus(1'b0, MODE_STAT_OFFSET, 4'hf, 32'h0, {2'b10, 32'h1});
        // every field combination, both code halves
        for (int i = 0; i < 16; i++) begin
            rnd = $urandom();
            cfg = {5'h00, i[2:0]};
            bus(1'b1, CODE_CTL_OFFSET, 4'h1, {rnd[31:1], i[3]}, 34'h0);
            bus(1'b1, RATE_CFG_OFFSET, 4'h1, {rnd[31:8], cfg}, 34'h0);
            bus(1'b0, RATE_CFG_OFFSET, 4'hf, 32'h0, {2'b10, 24'h0, cfg});
            bus(1'b0, MODE_STAT_OFFSET, 4'hf, 32'h0, {30'h2000_0000, expMode(cfg)});
            chkMode(cfg, i[3]);
        end
        // refused and ignored writes leave the register alone
        bus(1'b1, 8'h08, 4'h1, 32'h0, {2'b01, 32'h0});
        bus(1'b0, 8'h0c, 4'hf, 32'h0, {2'b01, 32'h0});
        bus(1'b1, RATE_CFG_OFFSET, 4'he, 32'h0, 34'h0);
        bus(1'b0, RATE_CFG_OFFSET, 4'hf, 32'h0, {2'b10, 32'h7});
        chkMode(8'h07, 1'b1);
        // a second reset in mid-run
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chkMode(8'h00, 1'b0);
        bus(1'b0, RATE_CFG_OFFSET, 4'hf, 32'h0, {2'b10, 32'h0});
        repeat (3) @(posedge core_clk);
        test_done();
    end
endmodule
